// ### design/oe_byte_reg.sv
// module: one byte-wide output-enable register with a per-bit write mask
`timescale 1ns/1ps
`default_nettype none

module oe_byte_reg #(
  parameter logic [7:0] WRITE_MASK = 8'hFF
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_data,
  output var  logic [7:0] value
);

  // masked bits load zero on every write, so reserved bits stay at their reset zero
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      value <= port_oe_pkg::OE_RESET_VALUE;
    end
    else if (wr_en)
    begin
      value <= wr_data & WRITE_MASK;
    end
  end

endmodule // oe_byte_reg

`default_nettype wire

// ### design/port_oe_pkg.sv
// package: register map, field layout and pad carrier for the port output-enable bank
package port_oe_pkg;

  // ----------------------------------------------------------------
  // bus geometry
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned BYTE_W = 8;

  // ----------------------------------------------------------------
  // register indices; byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] PORT_D_OE_INDEX = 16'h30B3;
  localparam logic [ADDR_W-1:0] PORT_E_OE_INDEX = 16'h30B4;
  localparam logic [ADDR_W-1:0] PORT_F_OE_INDEX = 16'h30B5;
  localparam logic [ADDR_W-1:0] PORT_G_OE_INDEX = 16'h30B6;

  // ----------------------------------------------------------------
  // field layout and reset values
  // ----------------------------------------------------------------
  localparam logic [BYTE_W-1:0] FULL_BYTE_MASK   = 8'hFF;
  localparam logic [BYTE_W-1:0] PORT_G_OE_MASK   = 8'h0F;
  localparam logic [BYTE_W-1:0] OE_RESET_VALUE   = 8'h00;
  localparam logic [DATA_W-1:0] READ_IDLE_VALUE  = 32'h0000_0000;
  localparam int unsigned       PORT_G_PINS      = 4;
  localparam int unsigned       WRITE_TO_PAD_CYC = 2;

  // ----------------------------------------------------------------
  // pad driver enables, one bit per pin
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [BYTE_W-1:0]      pd_drive_en;
    logic [BYTE_W-1:0]      pe_drive_en;
    logic [BYTE_W-1:0]      pf_drive_en;
    logic [PORT_G_PINS-1:0] pg_drive_en;
  } pad_drive_t;

  localparam pad_drive_t PAD_DRIVE_RESET = '0;

  // ----------------------------------------------------------------
  // byte address of a register index
  // ----------------------------------------------------------------
  function automatic logic [ADDR_W-1:0] byte_addr(input logic [ADDR_W-1:0] index);
    byte_addr = {index[ADDR_W-3:0], 2'b00};
  endfunction

  function automatic logic addr_hits(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] index);
    addr_hits = (addr == byte_addr(index));
  endfunction

endpackage

// ### design/port_oe_regs.sv
// module: APB slave holding the port D/E/F/G output-enable bytes and their pad driver enables
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// R1 - the port E enable byte sits at index 0x30B4, bit n steering pin n of port E.
// R2 - a one in a port E enable bit turns that pin's output driver on.
// R3 - a zero in a port E enable bit keeps that pin's output driver off.
// R4 - every enable bit is writable and reads back the value last written.
// R5 - the port F enable byte sits at index 0x30B5, bit n steering pin n of port F.
// R6 - a one in a port F enable bit turns that pin's output driver on.
// R7 - a zero in a port F enable bit keeps that pin's output driver off.
// R8 - the port G enable byte sits at index 0x30B6.
// R9 - port G bits 7 to 4 are reserved, read as zero and ignore writes.
// R10 - port D bit 0 enables its pin's driver when one and disables it when zero.
// R11 - port D bit 1 enables its pin's driver when one and disables it when zero.
// R12 - port G bits 3 to 0 are read/write enables, one per pin, one meaning output.
// R13 - the port D enable byte sits at index 0x30B3.
// R14 - reset clears every enable bit so all drivers start off.
// R15 - a completed write reaches the pad enables on the next clock edge after it.
module port_oe_regs (
  input  wire logic                             pclk,
  input  wire logic                             presetn,
  input  wire logic                             psel,
  input  wire logic                             penable,
  input  wire logic                             pwrite,
  input  wire logic [port_oe_pkg::ADDR_W-1:0]   paddr,
  input  wire logic [port_oe_pkg::DATA_W-1:0]   pwdata,
  input  wire logic [3:0]                       pstrb,
  output var  logic [port_oe_pkg::DATA_W-1:0]   prdata,
  output logic                                  pready,
  output var  logic                             pslverr,
  output var  port_oe_pkg::pad_drive_t          pad_drive
);

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  logic                              hit_d;
  logic                              hit_e;
  logic                              hit_f;
  logic                              hit_g;
  logic                              hit_any;
  logic                              setup_phase;
  logic                              access_phase;
  logic                              bus_write;
  logic [port_oe_pkg::BYTE_W-1:0]    wr_byte;
  logic [port_oe_pkg::BYTE_W-1:0]    d_value;
  logic [port_oe_pkg::BYTE_W-1:0]    e_value;
  logic [port_oe_pkg::BYTE_W-1:0]    f_value;
  logic [port_oe_pkg::BYTE_W-1:0]    g_value;
  logic [port_oe_pkg::DATA_W-1:0]    next_prdata;
  logic                              next_pslverr;
  port_oe_pkg::pad_drive_t           next_pad_drive;

  assign hit_d   = port_oe_pkg::addr_hits(paddr, port_oe_pkg::PORT_D_OE_INDEX); // [R13]
  assign hit_e   = port_oe_pkg::addr_hits(paddr, port_oe_pkg::PORT_E_OE_INDEX); // [R1]
  assign hit_f   = port_oe_pkg::addr_hits(paddr, port_oe_pkg::PORT_F_OE_INDEX); // [R5]
  assign hit_g   = port_oe_pkg::addr_hits(paddr, port_oe_pkg::PORT_G_OE_INDEX); // [R8]
  assign hit_any = hit_d | hit_e | hit_f | hit_g;

  assign setup_phase  = psel & ~penable;
  assign access_phase = psel & penable;

  // ----------------------------------------------------------------
  // bus handshake
  // ----------------------------------------------------------------
  // read data is staged in the setup cycle, so the access cycle never waits
  assign pready = access_phase;

  // only byte lane 0 carries data; a write without it is a no-op
  assign bus_write = access_phase & pready & pwrite & pstrb[0];
  assign wr_byte   = pwdata[port_oe_pkg::BYTE_W-1:0];

  // ----------------------------------------------------------------
  // enable registers
  // ----------------------------------------------------------------
  oe_byte_reg #(
    .WRITE_MASK (port_oe_pkg::FULL_BYTE_MASK)
  ) u_port_d (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_en   (bus_write & hit_d), // [R4] [R10] [R11]
    .wr_data (wr_byte),
    .value   (d_value)
  );

  oe_byte_reg #(
    .WRITE_MASK (port_oe_pkg::FULL_BYTE_MASK)
  ) u_port_e (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_en   (bus_write & hit_e), // [R4]
    .wr_data (wr_byte),
    .value   (e_value)
  );

  oe_byte_reg #(
    .WRITE_MASK (port_oe_pkg::FULL_BYTE_MASK)
  ) u_port_f (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_en   (bus_write & hit_f), // [R4]
    .wr_data (wr_byte),
    .value   (f_value)
  );

  // upper nibble masked off at the write, so it can never hold a one
  oe_byte_reg #(
    .WRITE_MASK (port_oe_pkg::PORT_G_OE_MASK)
  ) u_port_g (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_en   (bus_write & hit_g), // [R9] [R12]
    .wr_data (wr_byte),
    .value   (g_value)
  );

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  always_comb
  begin
    next_prdata  = prdata;
    next_pslverr = pslverr;
    if (setup_phase)
    begin
      next_prdata  = port_oe_pkg::READ_IDLE_VALUE;
      next_pslverr = ~hit_any;
      unique case (1'b1)
        hit_d:
        begin
          next_prdata[port_oe_pkg::BYTE_W-1:0] = d_value; // [R4]
        end
        hit_e:
        begin
          next_prdata[port_oe_pkg::BYTE_W-1:0] = e_value; // [R4]
        end
        hit_f:
        begin
          next_prdata[port_oe_pkg::BYTE_W-1:0] = f_value; // [R4]
        end
        hit_g:
        begin
          next_prdata[port_oe_pkg::BYTE_W-1:0] = g_value & port_oe_pkg::PORT_G_OE_MASK; // [R9]
        end
        default:
        begin
          next_prdata = port_oe_pkg::READ_IDLE_VALUE;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= port_oe_pkg::READ_IDLE_VALUE;
    end
    else
    begin
      prdata <= next_prdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pslverr <= 1'b0;
    end
    else
    begin
      pslverr <= next_pslverr;
    end
  end

  // ----------------------------------------------------------------
  // pad driver stage
  // ----------------------------------------------------------------
  // one flop between register and pad keeps the pad timing off the bus decode
  always_comb
  begin
    next_pad_drive             = port_oe_pkg::PAD_DRIVE_RESET;
    next_pad_drive.pd_drive_en = d_value;                                // [R10] [R11]
    next_pad_drive.pe_drive_en = e_value;                                // [R2] [R3]
    next_pad_drive.pf_drive_en = f_value;                                // [R6] [R7]
    next_pad_drive.pg_drive_en = g_value[port_oe_pkg::PORT_G_PINS-1:0];  // [R12]
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pad_drive <= port_oe_pkg::PAD_DRIVE_RESET; // [R14]
    end
    else
    begin
      pad_drive <= next_pad_drive; // [R15]
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking

  default disable iff (!presetn);

  logic wr_d;
  logic wr_e;
  logic wr_f;
  logic wr_g;
  logic rd_done;

  assign wr_d    = bus_write & hit_d;
  assign wr_e    = bus_write & hit_e;
  assign wr_f    = bus_write & hit_f;
  assign wr_g    = bus_write & hit_g;
  assign rd_done = access_phase & pready & ~pwrite & hit_any;

  a_e_write_pad: assert property ( // [R1]
    wr_e |=> ##1 (pad_drive.pe_drive_en == $past(wr_byte, 2)))
  else $error("port E write did not reach the pad two edges later");

  a_e_pad_onoff: assert property ( // [R2]
    pad_drive.pe_drive_en == $past(e_value))
  else $error("port E pad enable does not follow its register");

  a_e_zero_off: assert property ( // [R3]
    (e_value == 8'h00) |=> (pad_drive.pe_drive_en == 8'h00))
  else $error("port E driver on while its enables are zero");

  a_read_back: assert property ( // [R4]
    (setup_phase & ~pwrite & hit_e) ##1 rd_done |-> (prdata[7:0] == e_value))
  else $error("port E read did not return the stored value");

  a_f_write_pad: assert property ( // [R5]
    wr_f |=> ##1 (pad_drive.pf_drive_en == $past(wr_byte, 2)))
  else $error("port F write did not reach the pad two edges later");

  a_f_pad_onoff: assert property ( // [R6]
    $rose(f_value[0]) |=> pad_drive.pf_drive_en[0])
  else $error("port F bit 0 set but its driver stayed off");

  a_f_zero_off: assert property ( // [R7]
    $fell(f_value[7]) |=> !pad_drive.pf_drive_en[7])
  else $error("port F bit 7 cleared but its driver stayed on");

  a_g_write_value: assert property ( // [R8]
    wr_g |=> (g_value == ($past(wr_byte) & 8'h0F)))
  else $error("port G write stored the wrong value");

  a_g_reserved_zero: assert property ( // [R9]
    (g_value[7:4] == 4'h0) && !(rd_done && hit_g && (prdata[7:4] != 4'h0)))
  else $error("port G reserved bits not zero");

  a_d_bit0_pad: assert property ( // [R10]
    wr_d |=> ##1 (pad_drive.pd_drive_en[0] == $past(wr_byte[0], 2)))
  else $error("port D bit 0 pad enable wrong after write");

  a_d_bit1_pad: assert property ( // [R11]
    wr_d |=> ##1 (pad_drive.pd_drive_en[1] == $past(wr_byte[1], 2)))
  else $error("port D bit 1 pad enable wrong after write");

  a_g_pad_follow: assert property ( // [R12]
    wr_g |=> ##1 (pad_drive.pg_drive_en == $past(wr_byte[3:0], 2)))
  else $error("port G pad enables wrong after write");

  a_d_index_decode: assert property ( // [R13]
    (access_phase && paddr == 16'hC2CC) |-> (hit_d && !pslverr))
  else $error("port D index not decoded");

  a_unmapped_quiet: assert property ( // [R4]
    (bus_write && !hit_any) |=> $stable({d_value, e_value, f_value, g_value}))
  else $error("write to unmapped address changed a register");

  a_unmapped_err: assert property ( // [R4]
    (access_phase && !hit_any) |-> (pslverr && prdata == 32'h0000_0000))
  else $error("unmapped access not flagged");

  a_upper_zero: assert property ( // [R4]
    prdata[31:8] == 24'h00_0000)
  else $error("read data upper bits not zero");

  a_reset_drivers_off: assert property ( // [R14]
    $rose(presetn) |-> (pad_drive == port_oe_pkg::PAD_DRIVE_RESET))
  else $error("pad drivers not off after reset");

  a_pad_one_edge: assert property ( // [R15]
    wr_e |=> (pad_drive.pe_drive_en == $past(e_value)) ##1 (pad_drive.pe_drive_en == e_value))
  else $error("pad enable not updated on the edge after the write");

  // zero wait states: ready only in the access cycle, never in setup
  a_ready_access: assert property ( // [R4]
    access_phase |-> pready)
  else $error("pready low in an access cycle");

  a_ready_setup: assert property ( // [R4]
    setup_phase |-> !pready)
  else $error("pready high in a setup cycle");

  a_strobe_gate: assert property ( // [R4]
    (access_phase && pwrite && !pstrb[0]) |=> $stable({d_value, e_value, f_value, g_value}))
  else $error("write without lane 0 strobe changed a register");

  a_read_quiet: assert property ( // [R4]
    (access_phase && !pwrite) |=> $stable({d_value, e_value, f_value, g_value}))
  else $error("read access changed a register");

  a_d_read_back: assert property ( // [R4]
    (setup_phase & ~pwrite & hit_d) ##1 rd_done |-> (prdata[7:0] == d_value))
  else $error("port D read did not return the stored value");

  a_f_read_back: assert property ( // [R4]
    (setup_phase & ~pwrite & hit_f) ##1 rd_done |-> (prdata[7:0] == f_value))
  else $error("port F read did not return the stored value");

  a_g_read_back: assert property ( // [R12]
    (setup_phase & ~pwrite & hit_g) ##1 rd_done |-> (prdata[7:0] == g_value))
  else $error("port G read did not return the stored value");

  a_d_pad_follow: assert property ( // [R10] [R11]
    pad_drive.pd_drive_en == $past(d_value))
  else $error("port D pad enables do not follow their register");

  a_f_pad_follow: assert property ( // [R6] [R7]
    pad_drive.pf_drive_en == $past(f_value))
  else $error("port F pad enables do not follow their register");

  a_g_pad_track: assert property ( // [R12]
    pad_drive.pg_drive_en == $past(g_value[3:0]))
  else $error("port G pad enables do not follow their register");

  a_mapped_okay: assert property ( // [R1] [R5] [R8] [R13]
    (access_phase && hit_any) |-> !pslverr)
  else $error("mapped access flagged as an error");

  c_write_e:   cover property (wr_e ##2 (pad_drive.pe_drive_en != 8'h00));
  c_read_g:    cover property (rd_done && hit_g);
  c_unmapped:  cover property (access_phase && pslverr);
  c_back2back: cover property (wr_d ##1 setup_phase ##1 wr_e);

endmodule // port_oe_regs

`default_nettype wire

// ### tb/tb_port_oe_regs.sv
// testbench: self-checking APB bench for the port output-enable bank
`timescale 1ns/1ps
`default_nettype none

`define CHK(what, exp, got) \
  begin \
    n_compared++; \
    if ((got) !== (exp)) \
    begin \
      err_total++; \
      $display("[ERR] %s expected %h seen %h", what, exp, got); \
    end \
  end

module tb_port_oe_regs;

  typedef struct packed {
    logic                     wr;
    logic                     err;
    logic [31:0]              data;
    port_oe_pkg::pad_drive_t  pad;
  } note_t;

  logic                     pclk;
  logic                     presetn;
  logic                     psel;
  logic                     penable;
  logic                     pwrite;
  logic [15:0]              paddr;
  logic [31:0]              pwdata;
  logic [3:0]               pstrb;
  logic [31:0]              prdata;
  logic                     pready;
  logic                     pslverr;
  port_oe_pkg::pad_drive_t  pad_drive;

  note_t                    notes[$];
  port_oe_pkg::pad_drive_t  pad_q[$];
  note_t                    cur;
  port_oe_pkg::pad_drive_t  cur_pad;
  logic [7:0]               mdl[4];
  logic                     acc;
  logic                     wr_d1;
  logic                     wr_d2;
  int                       err_total;
  int                       n_compared;
  int                       seed;
  int                       i;
  int                       b;
  logic [31:0]              r;

  port_oe_regs port_oe_regs_i (
    .pclk      (pclk),
    .presetn   (presetn),
    .psel      (psel),
    .penable   (penable),
    .pwrite    (pwrite),
    .paddr     (paddr),
    .pwdata    (pwdata),
    .pstrb     (pstrb),
    .prdata    (prdata),
    .pready    (pready),
    .pslverr   (pslverr),
    .pad_drive (pad_drive)
  );

  // byte address of slot k: D, E, F, G
  function automatic logic [15:0] addr_of(input int k);
    logic [15:0] idx;
    case (k)
      0: idx = port_oe_pkg::PORT_D_OE_INDEX;
      1: idx = port_oe_pkg::PORT_E_OE_INDEX;
      2: idx = port_oe_pkg::PORT_F_OE_INDEX;
      default: idx = port_oe_pkg::PORT_G_OE_INDEX;
    endcase
    return 16'(idx * 4);
  endfunction

  task automatic give_verdict();
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // leaves the bus in the access phase; the next call follows back-to-back
  task automatic xfer(input logic wr, input logic [15:0] addr, input logic [31:0] data, input logic [3:0] strb);
    int    k;
    int    slot;
    logic  hit;
    note_t n;
    hit  = 1'b0;
    slot = 0;
    for (k = 0; k < 4; k++)
      if (addr == addr_of(k))
      begin
        hit  = 1'b1;
        slot = k;
      end
    if (wr && hit && strb[0])
      mdl[slot] = data[7:0] & ((slot == 3) ? port_oe_pkg::PORT_G_OE_MASK : port_oe_pkg::FULL_BYTE_MASK);
    n.wr   = wr;
    n.err  = !hit;
    n.data = (hit && !wr) ? {24'h00_0000, mdl[slot]} : 32'h0000_0000;
    n.pad  = port_oe_pkg::pad_drive_t'({mdl[0], mdl[1], mdl[2], mdl[3][3:0]});
    notes.push_back(n);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= data;
    pstrb   <= strb;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 16; k++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    if (k == 16)
    begin
      err_total++;
      $display("[ERR] pready expected 1 seen timeout");
      give_verdict();
    end
  endtask

  task automatic idle(input int n);
    psel    <= 1'b0;
    penable <= 1'b0;
    repeat (n) @(posedge pclk);
  endtask

  // ----------------------------------------------------------------
  // monitor
  // ----------------------------------------------------------------
  always @(posedge pclk)
  begin
    // pads are sampled one edge after they took the written value
    if (wr_d2 === 1'b1)
    begin
      cur_pad = pad_q.pop_front();
      `CHK("pad_drive", cur_pad, pad_drive)
    end
    acc = (psel === 1'b1 && penable === 1'b1 && pready === 1'b1);
    if (acc)
    begin
      cur = notes.pop_front();
      `CHK("pslverr", cur.err, pslverr)
      if (cur.wr)
        pad_q.push_back(cur.pad);
      else
        `CHK("prdata", cur.data, prdata)
    end
    wr_d2 <= wr_d1;
    wr_d1 <= acc && cur.wr;
  end

  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 16'h0000;
    pwdata  = 32'h0000_0000;
    pstrb   = 4'h0;
    wr_d1   = 1'b0;
    wr_d2   = 1'b0;
    err_total  = 0;
    n_compared = 0;
    seed    = 32'h7cc0_6760;
    for (i = 0; i < 4; i++)
      mdl[i] = 8'h00;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    `CHK("pad_drive at reset", port_oe_pkg::PAD_DRIVE_RESET, pad_drive)
    for (i = 0; i < 4; i++)
      xfer(1'b0, addr_of(i), 32'h0000_0000, 4'h0);
    idle(1);
    $display("test reset values done");
    for (i = 0; i < 4; i++)
    begin
      for (b = 0; b < 8; b++)
      begin
        xfer(1'b1, addr_of(i), 32'hFFFF_FF00 | (32'h1 << b), 4'hF);
        xfer(1'b0, addr_of(i), 32'h0000_0000, 4'h0);
      end
      xfer(1'b1, addr_of(i), 32'h0000_0000, 4'h1);
    end
    idle(3);
    $display("test walking enables done");
    repeat (32)
    begin
      r = $random(seed);
      xfer(1'b1, addr_of(int'(r[1:0])), $random(seed), r[7:4]);
      xfer(1'b0, addr_of(int'(r[1:0])), 32'h0000_0000, 4'h0);
    end
    idle(3);
    $display("test random writes done");
    xfer(1'b1, 16'hC2C8, 32'h0000_00FF, 4'hF);
    xfer(1'b1, 16'hC2DC, 32'h0000_00FF, 4'hF);
    xfer(1'b1, 16'hC2D1, 32'h0000_00FF, 4'hF);
    xfer(1'b0, 16'hC2C8, 32'h0000_0000, 4'h0);
    xfer(1'b0, 16'hC2D2, 32'h0000_0000, 4'h0);
    for (i = 0; i < 4; i++)
      xfer(1'b0, addr_of(i), 32'h0000_0000, 4'h0);
    idle(3);
    $display("test unmapped addresses done");
    for (i = 0; i < 4; i++)
      xfer(1'b1, addr_of(i), 32'h0000_00FF, 4'h1);
    idle(4);
    presetn <= 1'b0;
    for (i = 0; i < 4; i++)
      mdl[i] = 8'h00;
    repeat (3) @(posedge pclk);
    `CHK("pad_drive in reset", port_oe_pkg::PAD_DRIVE_RESET, pad_drive)
    presetn <= 1'b1;
    @(posedge pclk);
    for (i = 0; i < 4; i++)
      xfer(1'b0, addr_of(i), 32'h0000_0000, 4'h0);
    idle(3);
    $display("test second reset done");
    give_verdict();
  end

endmodule // tb_port_oe_regs

`default_nettype wire
